//--- design/rtctrm_pkg.sv
package rtctrm_pkg;
  // Register offsets on the register port
  localparam logic [3:0] OFS_DAY = 4'h4;
  localparam logic [3:0] OFS_TRIM = 4'h8;
  localparam logic [3:0] OFS_MATCH = 4'hA;
  // Values after reset
  localparam logic [7:0] RST_DAY = 8'h10;
  localparam logic [7:0] RST_TRIM = 8'h80;
  localparam logic [7:0] RST_MATCH = 8'h40;
  // Writable bits; the others read as zero
  localparam logic [7:0] WMASK_DAY = 8'hF7;
  localparam logic [7:0] WMASK_TRIM = 8'hBF;
  localparam logic [7:0] WMASK_MATCH = 8'hDF;
  // Field positions
  localparam int SEL_LSB = 4;
  localparam int OE_BIT = 6;
  localparam int SIGN_BIT = 5;
  localparam int MAG_LSB = 0;
  // Selector codes
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_FULL = 4'h1;
  // Divider chain counts, in oscillator cycles or stage steps
  localparam logic [7:0] PRE_LAST = 8'hFF;
  localparam logic [7:0] STRETCH_LOAD = 8'h80;
  localparam logic [6:0] SUB_LAST = 7'h7F;
  localparam logic [6:0] SUB_SKIP = 7'h7E;
  localparam logic [5:0] SEC_LAST = 6'h3B;
endpackage : rtctrm_pkg

//--- design/rtctrm_link_if.sv
`timescale 1ns/1ps
interface rtctrm_link_if;
  logic osc_tick;
  logic [14:0] taps;
  logic [4:0] mag;
  logic pos;
  logic sec_tick;
  logic trim_evt;
  modport ctl (output osc_tick, output mag, output pos, input taps, input sec_tick, input trim_evt);
  modport div (input osc_tick, output taps);
  modport trim (input osc_tick, input mag, input pos, output sec_tick, output trim_evt);
endinterface : rtctrm_link_if

//--- design/rtctrm_wave_div.sv
`timescale 1ns/1ps
module rtctrm_wave_div (
  input wire logic mclk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  rtctrm_link_if.div lnk // Oscillator tick in, divider taps out
);
  typedef struct packed {
    logic [14:0] cnt;
  } rtctrm_div_t;

  rtctrm_div_t st_r;
  rtctrm_div_t st_nxt;

  // Free-running chain ahead of the correction point
  always_comb begin
    st_nxt = st_r;
    if (!nrst) begin
      st_nxt.cnt = 15'h0000;
    end else if (lnk.osc_tick) begin
      st_nxt.cnt = 15'(st_r.cnt + 15'h0001);
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  assign lnk.taps = st_r.cnt;

  a_div_count: assert property (@(posedge mclk) disable iff (!nrst)
    lnk.osc_tick |=> st_r.cnt == 15'($past(st_r.cnt) + 15'h0001))
    else $error("wave divider missed an oscillator tick");
  a_div_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !lnk.osc_tick |=> $stable(st_r.cnt))
    else $error("wave divider moved without a tick");
endmodule : rtctrm_wave_div

//--- design/rtctrm_rate_trim.sv
`timescale 1ns/1ps
module rtctrm_rate_trim (
  input wire logic mclk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  rtctrm_link_if.trim lnk // Oscillator tick and trim value in, second tick out
);
  typedef struct packed {
    logic [7:0] pre;
    logic [6:0] sub;
    logic [5:0] sec;
    logic [5:0] minute;
    logic stretch;
    logic sec_tick;
    logic evt;
  } rtctrm_trim_t;

  rtctrm_trim_t st_r;
  rtctrm_trim_t st_nxt;
  logic due;

  // One event in second 0 of each of the first 2N minutes
  assign due = (st_r.sec == 6'h00) && ({1'b0, st_r.minute} < {1'b0, lnk.mag, 1'b0});

  always_comb begin
    logic end_sec;
    end_sec = 1'b0;
    st_nxt = st_r;
    st_nxt.sec_tick = 1'b0;
    st_nxt.evt = 1'b0;
    if (!nrst) begin
      st_nxt = '0;
    end else if (lnk.osc_tick) begin
      if (st_r.pre != rtctrm_pkg::PRE_LAST) begin
        st_nxt.pre = 8'(st_r.pre + 8'h01);
      end else begin
        st_nxt.pre = 8'h00;
        if (st_r.stretch) begin
          st_nxt.stretch = 1'b0;
          end_sec = 1'b1;
        end else if (st_r.sub == rtctrm_pkg::SUB_SKIP && due && !lnk.pos) begin
          // Drop the last 128 Hz step: second is 256 cycles short
          end_sec = 1'b1;
          st_nxt.evt = 1'b1;
        end else if (st_r.sub == rtctrm_pkg::SUB_LAST) begin
          if (due && lnk.pos) begin
            // Run half a step more: second is 128 cycles longer
            st_nxt.pre = rtctrm_pkg::STRETCH_LOAD;
            st_nxt.stretch = 1'b1;
            st_nxt.evt = 1'b1;
          end else begin
            end_sec = 1'b1;
          end
        end else begin
          st_nxt.sub = 7'(st_r.sub + 7'h01);
        end
      end
      if (end_sec) begin
        st_nxt.sub = 7'h00;
        st_nxt.sec_tick = 1'b1;
        if (st_r.sec == rtctrm_pkg::SEC_LAST) begin
          st_nxt.sec = 6'h00;
          st_nxt.minute = 6'(st_r.minute + 6'h01);
        end else begin
          st_nxt.sec = 6'(st_r.sec + 6'h01);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  assign lnk.sec_tick = st_r.sec_tick;
  assign lnk.trim_evt = st_r.evt;

  a_zero_no_evt: assert property (@(posedge mclk) disable iff (!nrst)
    $past(lnk.mag) == 5'h00 |-> !st_r.evt)
    else $error("trim event with zero magnitude");
  a_evt_window: assert property (@(posedge mclk) disable iff (!nrst)
    st_r.evt |-> ({1'b0, $past(st_r.minute)} < {1'b0, $past(lnk.mag), 1'b0}) && $past(st_r.sec) == 6'h00)
    else $error("trim event outside its minutes");
  a_neg_short: assert property (@(posedge mclk) disable iff (!nrst)
    st_r.evt && !$past(lnk.pos) |-> st_r.sec_tick && st_r.sub == 7'h00 && st_r.pre == 8'h00)
    else $error("negative event did not end the second early");
  a_pos_long: assert property (@(posedge mclk) disable iff (!nrst)
    st_r.evt && $past(lnk.pos) |-> st_r.stretch && st_r.pre == 8'h80 && !st_r.sec_tick)
    else $error("positive event did not stretch the second");
endmodule : rtctrm_rate_trim

//--- design/rtctrm_top.sv
`timescale 1ns/1ps
module rtctrm_top (
  input wire logic mclk, // System clock, 10 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic osc_in, // Crystal oscillator level, asynchronous
  input wire logic [3:0] reg_addr, // Register offset
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, one cycle after reg_rd
  output logic square_wave_out, // Programmable square wave
  output logic second_tick, // One pulse per trimmed second
  output logic trim_event // One pulse per compensation event
);
  typedef struct packed {
    logic osc_s1;
    logic osc_s2;
    logic osc_prev;
    logic [7:0] day;
    logic [7:0] trim;
    logic [7:0] match;
    logic [7:0] rdata;
    logic sq_out;
  } rtctrm_top_t;

  rtctrm_top_t st_r;
  rtctrm_top_t st_nxt;
  rtctrm_link_if lnk ();

  logic [3:0] out_freq_select;
  logic square_wave_out_enable;
  logic wave_src;

  assign out_freq_select = st_r.day[rtctrm_pkg::SEL_LSB +: 4];
  assign square_wave_out_enable = st_r.match[rtctrm_pkg::OE_BIT];

  // Wave source is the untrimmed chain, so trim events never reach it
  always_comb begin
    unique case (out_freq_select)
      rtctrm_pkg::SEL_NONE: begin
        wave_src = 1'b0;
      end
      rtctrm_pkg::SEL_FULL: begin
        wave_src = st_r.osc_s2;
      end
      4'h2: begin
        wave_src = lnk.taps[1];
      end
      4'h3: begin
        wave_src = lnk.taps[2];
      end
      4'h4: begin
        wave_src = lnk.taps[3];
      end
      4'h5: begin
        wave_src = lnk.taps[4];
      end
      4'h6: begin
        wave_src = lnk.taps[5];
      end
      4'h7: begin
        wave_src = lnk.taps[6];
      end
      4'h8: begin
        wave_src = lnk.taps[7];
      end
      4'h9: begin
        wave_src = lnk.taps[8];
      end
      4'hA: begin
        wave_src = lnk.taps[9];
      end
      4'hB: begin
        wave_src = lnk.taps[10];
      end
      4'hC: begin
        wave_src = lnk.taps[11];
      end
      4'hD: begin
        wave_src = lnk.taps[12];
      end
      4'hE: begin
        wave_src = lnk.taps[13];
      end
      4'hF: begin
        wave_src = lnk.taps[14];
      end
    endcase
  end

  assign lnk.osc_tick = st_r.osc_s2 && !st_r.osc_prev;
  assign lnk.mag = st_r.trim[rtctrm_pkg::MAG_LSB +: 5];
  assign lnk.pos = st_r.trim[rtctrm_pkg::SIGN_BIT];

  always_comb begin
    st_nxt = st_r;
    st_nxt.osc_s1 = osc_in;
    st_nxt.osc_s2 = st_r.osc_s1;
    st_nxt.osc_prev = st_r.osc_s2;
    if (!nrst) begin
      st_nxt.day = rtctrm_pkg::RST_DAY;
      st_nxt.trim = rtctrm_pkg::RST_TRIM;
      st_nxt.match = rtctrm_pkg::RST_MATCH;
      st_nxt.rdata = 8'h00;
      st_nxt.sq_out = 1'b0;
    end else begin
      if (reg_wr) begin
        unique case (reg_addr)
          rtctrm_pkg::OFS_DAY: begin
            st_nxt.day = reg_wdata & rtctrm_pkg::WMASK_DAY;
          end
          rtctrm_pkg::OFS_TRIM: begin
            st_nxt.trim = reg_wdata & rtctrm_pkg::WMASK_TRIM;
          end
          rtctrm_pkg::OFS_MATCH: begin
            st_nxt.match = reg_wdata & rtctrm_pkg::WMASK_MATCH;
          end
          default: begin
          end
        endcase
      end
      if (reg_rd) begin
        unique case (reg_addr)
          rtctrm_pkg::OFS_DAY: begin
            st_nxt.rdata = st_r.day;
          end
          rtctrm_pkg::OFS_TRIM: begin
            st_nxt.rdata = st_r.trim;
          end
          rtctrm_pkg::OFS_MATCH: begin
            st_nxt.rdata = st_r.match;
          end
          default: begin
            st_nxt.rdata = 8'h00;
          end
        endcase
      end
      // Pin is held low while disabled
      st_nxt.sq_out = square_wave_out_enable && (out_freq_select != rtctrm_pkg::SEL_NONE) && wave_src;
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  rtctrm_wave_div u_div (
    .mclk(mclk),
    .nrst(nrst),
    .lnk(lnk.div)
  );

  rtctrm_rate_trim u_trim (
    .mclk(mclk),
    .nrst(nrst),
    .lnk(lnk.trim)
  );

  assign reg_rdata = st_r.rdata;
  assign square_wave_out = st_r.sq_out;
  assign second_tick = lnk.sec_tick;
  assign trim_event = lnk.trim_evt;

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_sel_zero_off: assert property (
    out_freq_select == 4'h0 |=> !square_wave_out)
    else $error("square wave active with selector zero");
  a_oe_clear_off: assert property (
    !square_wave_out_enable |=> !square_wave_out)
    else $error("square wave active while disabled");
  a_full_rate: assert property (
    square_wave_out_enable && out_freq_select == 4'h1 |=> square_wave_out == $past(st_r.osc_s2))
    else $error("selector one does not pass the oscillator");
  a_tap_follow: assert property (
    square_wave_out_enable && out_freq_select == 4'hF |=> square_wave_out == $past(lnk.taps[14]))
    else $error("slowest selector not taken from top tap");
  a_reset_default: assert property (@(posedge mclk) disable iff (1'b0)
    !nrst |=> st_r.day[7:4] == 4'h1 && st_r.match[6] && st_r.trim[4:0] == 5'h00)
    else $error("power-up defaults wrong");
  a_trim_write: assert property (
    reg_wr && reg_addr == 4'h8 |=> st_r.trim[5:0] == $past(reg_wdata[5:0]) && !st_r.trim[6])
    else $error("trim register write not stored");
  a_osc_tick_edge: assert property (
    lnk.osc_tick |=> !lnk.osc_tick)
    else $error("oscillator tick longer than one cycle");

  // Each divided code N takes chain bit N-1; from code 3 on that is one step slower than the code before
  a_tap_code2: assert property (
    square_wave_out_enable && out_freq_select == 4'h2 |=> square_wave_out == $past(lnk.taps[1]))
    else $error("selector two not taken from its tap");
  a_tap_code3: assert property (
    square_wave_out_enable && out_freq_select == 4'h3 |=> square_wave_out == $past(lnk.taps[2]))
    else $error("selector three not taken from its tap");
  a_tap_code4: assert property (
    square_wave_out_enable && out_freq_select == 4'h4 |=> square_wave_out == $past(lnk.taps[3]))
    else $error("selector four not taken from its tap");
  a_tap_code5: assert property (
    square_wave_out_enable && out_freq_select == 4'h5 |=> square_wave_out == $past(lnk.taps[4]))
    else $error("selector five not taken from its tap");
  a_tap_code6: assert property (
    square_wave_out_enable && out_freq_select == 4'h6 |=> square_wave_out == $past(lnk.taps[5]))
    else $error("selector six not taken from its tap");
  a_tap_code7: assert property (
    square_wave_out_enable && out_freq_select == 4'h7 |=> square_wave_out == $past(lnk.taps[6]))
    else $error("selector seven not taken from its tap");
  a_tap_code8: assert property (
    square_wave_out_enable && out_freq_select == 4'h8 |=> square_wave_out == $past(lnk.taps[7]))
    else $error("selector eight not taken from its tap");
  a_tap_code9: assert property (
    square_wave_out_enable && out_freq_select == 4'h9 |=> square_wave_out == $past(lnk.taps[8]))
    else $error("selector nine not taken from its tap");
  a_tap_code10: assert property (
    square_wave_out_enable && out_freq_select == 4'hA |=> square_wave_out == $past(lnk.taps[9]))
    else $error("selector ten not taken from its tap");
  a_tap_code11: assert property (
    square_wave_out_enable && out_freq_select == 4'hB |=> square_wave_out == $past(lnk.taps[10]))
    else $error("selector eleven not taken from its tap");
  a_tap_code12: assert property (
    square_wave_out_enable && out_freq_select == 4'hC |=> square_wave_out == $past(lnk.taps[11]))
    else $error("selector twelve not taken from its tap");
  a_tap_code13: assert property (
    square_wave_out_enable && out_freq_select == 4'hD |=> square_wave_out == $past(lnk.taps[12]))
    else $error("selector thirteen not taken from its tap");
  a_tap_code14: assert property (
    square_wave_out_enable && out_freq_select == 4'hE |=> square_wave_out == $past(lnk.taps[13]))
    else $error("selector fourteen not taken from its tap");

  // Register port
  a_day_write: assert property (
    reg_wr && reg_addr == 4'h4 |=> st_r.day == ($past(reg_wdata) & 8'hF7))
    else $error("day register write not stored");
  a_match_write: assert property (
    reg_wr && reg_addr == 4'hA |=> st_r.match == ($past(reg_wdata) & 8'hDF))
    else $error("month register write not stored");
  a_day_hold: assert property (
    !(reg_wr && reg_addr == 4'h4) |=> $stable(st_r.day))
    else $error("day register changed without a write");
  a_trim_hold: assert property (
    !(reg_wr && reg_addr == 4'h8) |=> $stable(st_r.trim))
    else $error("trim register changed without a write");
  a_match_hold: assert property (
    !(reg_wr && reg_addr == 4'hA) |=> $stable(st_r.match))
    else $error("month register changed without a write");
  a_wr_unmapped: assert property (
    reg_wr && reg_addr != 4'h4 && reg_addr != 4'h8 && reg_addr != 4'hA
      |=> $stable(st_r.day) && $stable(st_r.trim) && $stable(st_r.match))
    else $error("write to an unmapped offset changed a register");
  a_rd_day: assert property (
    reg_rd && reg_addr == 4'h4 |=> reg_rdata == $past(st_r.day))
    else $error("day register read wrong");
  a_rd_trim: assert property (
    reg_rd && reg_addr == 4'h8 |=> reg_rdata == $past(st_r.trim))
    else $error("trim register read wrong");
  a_rd_match: assert property (
    reg_rd && reg_addr == 4'hA |=> reg_rdata == $past(st_r.match))
    else $error("month register read wrong");
  a_rd_unmapped: assert property (
    reg_rd && reg_addr != 4'h4 && reg_addr != 4'h8 && reg_addr != 4'hA |=> reg_rdata == 8'h00)
    else $error("unmapped offset did not read zero");
  a_rd_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // Output pin and pulses
  a_wave_gated: assert property (
    square_wave_out |-> $past(square_wave_out_enable) && $past(out_freq_select) != 4'h0)
    else $error("square wave high while gated off");
  a_reset_outputs: assert property (@(posedge mclk) disable iff (1'b0)
    !nrst |=> reg_rdata == 8'h00 && !square_wave_out)
    else $error("outputs not cleared by reset");
  a_tick_pulse: assert property (
    second_tick |=> !second_tick)
    else $error("second tick longer than one cycle");
  a_evt_pulse: assert property (
    trim_event |=> !trim_event)
    else $error("trim event longer than one cycle");
  a_neg_evt_ends: assert property (
    trim_event && !$past(lnk.pos) |-> second_tick)
    else $error("negative event without an early second end");
  a_pos_evt_alone: assert property (
    trim_event && $past(lnk.pos) |-> !second_tick)
    else $error("positive event ended the second at once");
  a_evt_needs_mag: assert property (
    trim_event |-> $past(lnk.mag) != 5'h00)
    else $error("trim event with zero magnitude");
endmodule : rtctrm_top

//--- verif/rtctrm_wave_sink.sv
`timescale 1ns/1ps
module rtctrm_wave_sink (
  input wire logic mclk, // System clock
  input wire logic wave, // Square wave taken from the pin
  output logic [31:0] period, // Cycles between the last two rising edges
  output logic [31:0] rises // Rising edges seen so far
);
  logic last_r = 1'b1;
  logic [31:0] cnt_r = 32'h0;
  logic [31:0] period_r = 32'h0;
  logic [31:0] rises_r = 32'h0;
  // Load that only counts edges, as the circuit on the pin would
  always @(posedge mclk) begin
    last_r <= wave;
    if (wave === 1'b1 && last_r === 1'b0) begin
      period_r <= cnt_r;
      cnt_r <= 32'h1;
      rises_r <= rises_r + 32'h1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
  assign period = period_r;
  assign rises = rises_r;
endmodule : rtctrm_wave_sink

//--- verif/test_square_wave_out_divider_and_rate_trim.sv
`timescale 1ns/1ps
module test_square_wave_out_divider_and_rate_trim;
  logic mclk;
  logic nrst;
  logic osc_in;
  logic [3:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic square_wave_out;
  logic second_tick;
  logic trim_event;
  logic [31:0] period;
  logic [31:0] rises;
  int mismatches;
  int checked;
  logic [31:0] up_cyc;
  localparam int OSC_CYC = 2; // mclk cycles per oscillator period in this bench
  localparam int SEC_TICKS = 32768; // Oscillator cycles in an untrimmed second
  localparam int NEG_SHORT = 256; // Oscillator cycles removed by a negative event

  rtctrm_top i_dut (
    .mclk(mclk),
    .nrst(nrst),
    .osc_in(osc_in),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .square_wave_out(square_wave_out),
    .second_tick(second_tick),
    .trim_event(trim_event)
  );

  rtctrm_wave_sink i_sink (
    .mclk(mclk),
    .wave(square_wave_out),
    .period(period),
    .rises(rises)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Oscillator stand-in: one period per OSC_CYC mclk cycles, edges away from mclk
  initial begin
    osc_in = 1'b0;
    forever begin
      repeat (OSC_CYC / 2) @(posedge mclk);
      #37 osc_in = ~osc_in;
    end
  end

  // Cycles since reset release, to time the first trimmed second
  always @(posedge mclk) begin
    up_cyc <= nrst ? 32'(up_cyc + 32'h1) : 32'h0;
  end

  task wrap_up;
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task tick(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask : tick

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr

  task reg_chk(input logic [3:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    check("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
  endtask : reg_chk

  task wait_rises(input int n);
    logic [31:0] start;
    int i;
    start = rises;
    for (i = 0; i < 20000 && rises < start + n; i++) begin
      tick(1);
    end
    if (rises < start + n) begin
      mismatches++;
      $display("MISMATCH wave_rises expected %0d seen %0d", n, rises - start);
      wrap_up();
    end
  endtask : wait_rises

  task idle_chk;
    logic [31:0] start;
    tick(4);
    start = rises;
    tick(300);
    check("idle_rises", start, rises);
    check("idle_level", 32'h0, {31'h0, square_wave_out});
  endtask : idle_chk

  task wait_second;
    int i;
    for (i = 0; i < 70000 && second_tick !== 1'b1; i++) begin
      tick(1);
    end
    if (second_tick !== 1'b1) begin
      mismatches++;
      $display("MISMATCH second_tick expected 1 seen 0");
      wrap_up();
    end
    check("second_len", (SEC_TICKS - NEG_SHORT) * OSC_CYC, up_cyc);
    check("trim_event", 32'h1, {31'h0, trim_event});
  endtask : wait_second

  initial begin
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    mismatches = 0;
    checked = 0;
    tick(2);
    nrst = 1'b1;
    reg_chk(4'h4, 8'h10);
    reg_chk(4'h8, 8'h80);
    reg_chk(4'hA, 8'h40);
    wr(4'h3, 8'hFF);
    reg_chk(4'h3, 8'h00);
    wait_rises(3);
    check("period", OSC_CYC, period);
    wr(4'h4, 8'hFF);
    reg_chk(4'h4, 8'hF7);
    wr(4'h8, 8'hFF);
    reg_chk(4'h8, 8'hBF);
    wr(4'hA, 8'hFF);
    reg_chk(4'hA, 8'hDF);
    wr(4'h8, 8'h1F);
    reg_chk(4'h8, 8'h1F);
    for (int k = 1; k < 10; k++) begin
      wr(4'h4, {k[3:0], 4'h0});
      wait_rises(3);
      check("period", (k == 1) ? OSC_CYC : (OSC_CYC << k), period);
    end
    wr(4'hA, 8'h00);
    idle_chk();
    wr(4'hA, 8'h40);
    wr(4'h4, 8'h00);
    idle_chk();
    wr(4'h4, 8'h10);
    wait_rises(3);
    check("period", OSC_CYC, period);
    wr(4'hA, 8'h00);
    wait_second();
    wrap_up();
  end
endmodule : test_square_wave_out_divider_and_rate_trim
